/* File: dv/iabf_host_model.sv */
// Purpose: Host model issuing byte writes and word reads to the register bank
// Assumes: One command per request pulse, read answer registered at the taking edge
// Notes:   Released address and data lines show the inverse of their last value
`timescale 1ns/1ns
module iabf_host_model (
	input  wire logic        clk,
	output logic             regReq,
	output logic             regWrite,
	output logic [6:0]       regAddr,
	output logic [7:0]       regWrData,
	input  wire logic [15:0] regRdData,
	input  wire logic        regRdValid
);
	// ---------------------------------------------------------------
	// Command tasks
	// ---------------------------------------------------------------
	// Quiet bus at time zero
	initial begin
		regReq    = 1'b0;
		regWrite  = 1'b0;
		regAddr   = 7'h00;
		regWrData = 8'h00;
	end

	// Raise after an edge, drop after the taking edge; one idle cycle between commands
	task automatic issue(input logic wr, input logic [6:0] a, input logic [7:0] d);
		@(posedge clk);
		#1;
		regReq    = 1'b1;
		regWrite  = wr;
		regAddr   = a;
		regWrData = d;
		@(posedge clk);
		#1;
		regReq    = 1'b0;
		regWrite  = ~wr;
		regAddr   = ~a;  // Stale lines must never look like the last address
		regWrData = ~d;
	endtask

	// Word read: answer is registered at the taking edge
	task automatic rd(input logic [6:0] a, output logic [15:0] data, output logic valid);
		issue(1'b0, a, 8'h00);
		valid = regRdValid;
		data  = regRdData;
	endtask

	// Filter size: low byte first, then zero into the high byte
	task automatic setFilter(input logic [2:0] b);
		issue(1'b1, iabf_pkg::ADDR_FILTER, {5'h00, b});
		issue(1'b1, iabf_pkg::ADDR_FILTER + 7'h01, 8'h00);
	endtask
endmodule // iabf_host_model

/* File: dv/tb.sv */
// Purpose: Self-checking bench for the bias, filter and misc register bank
// Assumes: Range code 3 build with burst controls present
// Notes:   Inputs change 1 ns after the rising edge
`timescale 1ns/1ns
module tb;
	logic             clk;
	logic             srst;
	logic             sampleStrobe;
	logic [2:0][31:0] accelRaw;
	logic             regReq;
	logic             regWrite;
	logic [6:0]       regAddr;
	logic [7:0]       regWrData;
	logic [15:0]      regRdData;
	logic             regRdValid;
	logic [2:0][31:0] accelFiltered;
	logic             accelFilteredValid;
	logic             sampleValidFlag;
	logic             burstWideWords;
	logic             burstDeltaSel;
	logic             linearGComp;
	logic             percussionAlign;
	logic [2:0]       syncMode;
	logic             syncRisingEdge;
	int               failures;
	int               nChecks;
	int               cycles;

	iabf_regs #(.GYRO_RANGE(2'h3), .HAS_BURST_CTL(1'b1)) dut (
		.clk(clk), .srst(srst), .regReq(regReq), .regWrite(regWrite),
		.regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData),
		.regRdValid(regRdValid), .sampleStrobe(sampleStrobe), .accelRaw(accelRaw),
		.accelFiltered(accelFiltered), .accelFilteredValid(accelFilteredValid),
		.sampleValidFlag(sampleValidFlag), .burstWideWords(burstWideWords),
		.burstDeltaSel(burstDeltaSel), .linearGComp(linearGComp),
		.percussionAlign(percussionAlign), .syncMode(syncMode),
		.syncRisingEdge(syncRisingEdge)
	);

	iabf_host_model host (
		.clk(clk), .regReq(regReq), .regWrite(regWrite), .regAddr(regAddr),
		.regWrData(regWrData), .regRdData(regRdData), .regRdValid(regRdValid)
	);

	// ---------------------------------------------------------------
	// Clock, timeout and helpers
	// ---------------------------------------------------------------
	// 50 MHz clock
	always #10 clk = ~clk;

	// Hang guard, far above the 150 cycles the tests need
	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			failures++;
			results();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		nChecks++;
		if (got !== exp) begin
			failures++;
			$display("unexpected at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask

	// Control outputs packed for one compare
	function automatic logic [31:0] outs();
		return {23'h0, burstWideWords, burstDeltaSel, linearGComp, percussionAlign,
			syncMode, syncRisingEdge, sampleValidFlag};
	endfunction

	task automatic rdChk(input logic [6:0] a, input logic [15:0] exp);
		logic [15:0] d;
		logic        v;
		host.rd(a, d, v);
		chk({31'h0, v}, 32'h1);
		chk({16'h0, d}, {16'h0, exp});
	endtask

	task automatic doReset(input int n);
		@(posedge clk);
		#1;
		srst = 1'b1;
		repeat (n) @(posedge clk);
		#1;
		srst = 1'b0;
	endtask

	// One strobe; raw lines go stale afterwards
	task automatic strobe(input logic [2:0][31:0] raw);
		@(posedge clk);
		#1;
		sampleStrobe = 1'b1;
		accelRaw     = raw;
		@(posedge clk);
		#1;
		sampleStrobe = 1'b0;
		accelRaw     = ~raw;
	endtask

	// Result lands two edges after the edge that takes the strobe
	task automatic sample(input logic [2:0][31:0] raw, input logic [2:0][31:0] exp);
		strobe(raw);
		repeat (2) @(posedge clk);
		#1;
		chk({31'h0, accelFilteredValid}, 32'h1);
		chk({31'h0, sampleValidFlag}, 32'h1);
		for (int i = 0; i < 3; i++) chk(accelFiltered[i], exp[i]);
	endtask

	// ---------------------------------------------------------------
	// Scenarios
	// ---------------------------------------------------------------
	task automatic testDefaults();
		for (int a = 'h4c; a <= 'h56; a += 2) rdChk(7'(a), 16'h0000);
		rdChk(iabf_pkg::ADDR_FILTER, 16'h0000);
		rdChk(iabf_pkg::ADDR_RANGE, 16'h000f);
		host.issue(1'b1, iabf_pkg::ADDR_RANGE, 8'h00);
		rdChk(iabf_pkg::ADDR_RANGE, 16'h000f);
		rdChk(iabf_pkg::ADDR_MISC, 16'h00c1);
		rdChk(7'h58, 16'h0000);
		chk(outs(), 32'h0000_0060);
		$display("test defaults done");
	endtask

	task automatic testBias();
		logic [6:0] wa [9] = '{7'h4c, 7'h4d, 7'h4e, 7'h4f, 7'h50, 7'h51, 7'h52, 7'h53, 7'h54};
		logic [7:0] wd [9] = '{8'h34, 8'h12, 8'h01, 8'h00, 8'hff, 8'hff, 8'hff, 8'hff, 8'h05};
		for (int i = 0; i < 9; i++) host.issue(1'b1, wa[i], wd[i]);
		rdChk(7'h4c, 16'h1234);
		rdChk(7'h4e, 16'h0001);
		rdChk(7'h50, 16'hffff);
		rdChk(7'h52, 16'hffff);
		rdChk(7'h54, 16'h0005);
		rdChk(7'h56, 16'h0000);
		// One tap: output is raw plus the joined offset
		sample({32'h100, 32'h10, 32'h10}, {32'h105, 32'h0f, 32'h11244});
		$display("test bias done");
	endtask

	task automatic testFilter();
		doReset(2);
		host.setFilter(3'h4);
		rdChk(iabf_pkg::ADDR_FILTER, 16'h0004);
		host.issue(1'b1, iabf_pkg::ADDR_FILTER + 7'h01, 8'hff);
		rdChk(iabf_pkg::ADDR_FILTER, 16'h0004);
		// Two taps per stage: cascaded ramp from zeroed history
		host.setFilter(3'h1);
		sample({32'h0, -32'sd8, 32'h8}, {32'h0, -32'sd2, 32'h2});
		sample({32'h0, -32'sd8, 32'h8}, {32'h0, -32'sd6, 32'h6});
		sample({32'h0, -32'sd8, 32'h8}, {32'h0, -32'sd8, 32'h8});
		$display("test filter done");
	endtask

	task automatic testBurst();
		host.issue(1'b1, iabf_pkg::ADDR_MISC + 7'h01, 8'hff);
		rdChk(iabf_pkg::ADDR_MISC, 16'h03c1);
		chk({31'h0, burstDeltaSel}, 32'h1);
		// Host waits a full sample period before relying on the width
		strobe('0);
		repeat (3) @(posedge clk);
		#1;
		chk({31'h0, burstWideWords}, 32'h0);
		strobe('0);
		repeat (2) @(posedge clk);
		#1;
		chk({31'h0, burstWideWords}, 32'h1);
		$display("test burst done");
	endtask

	task automatic testMisc();
		logic [2:0] c;
		for (int i = 0; i < 8; i++) begin
			c = 3'(i);
			host.issue(1'b1, iabf_pkg::ADDR_MISC, {3'h1, c, 2'h2});
			rdChk(iabf_pkg::ADDR_MISC, {8'h03, 3'h0, c, 2'h2});
			chk(outs(), {23'h0, 4'hc, c, 2'h3});
		end
		// Polarity now low: the pin must drop while the result is valid
		strobe('0);
		repeat (2) @(posedge clk);
		#1;
		chk({31'h0, accelFilteredValid}, 32'h1);
		chk({31'h0, sampleValidFlag}, 32'h0);
		@(posedge clk);
		#1;
		chk({31'h0, sampleValidFlag}, 32'h1);
		$display("test misc done");
	endtask

	task automatic results();
		$display("checks %0d, mismatches %0d", nChecks, failures);
		if (failures == 0 && nChecks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// Main sequence
	initial begin
		clk          = 1'b0;
		srst         = 1'b1;
		sampleStrobe = 1'b0;
		accelRaw     = '0;
		failures     = 0;
		nChecks      = 0;
		cycles       = 0;
		doReset(12);
		testDefaults();
		testBias();
		testFilter();
		testBurst();
		testMisc();
		results();
	end
endmodule // tb

/* File: logic/iabf_boxcar.sv */
// Purpose: One running-sum averaging stage with 2^B taps
// Assumes: Signed 32-bit samples, B from 0 to 7
// Notes:   History starts at zero, so the output ramps after reset or flush
`timescale 1ns/1ns
module iabf_boxcar (
	input  wire logic clk,
	input  wire logic srst,
	iabf_avg_if.stage lnk
);

	logic [31:0]             hist_reg [iabf_pkg::HIST_DEPTH];
	logic [6:0]              wrPtr_reg;
	logic signed [38:0]      sum_reg;
	logic signed [38:0]      sum_next;
	logic [31:0]             outData_reg;
	logic                    outValid_reg;
	logic [7:0]              tapCount;
	logic [6:0]              oldIdx;
	logic [31:0]             oldSample;
	logic signed [38:0]      avgShift;

	// ---------------------------------------------------------------
	// Running sum: add newest, drop the one N samples back
	// ---------------------------------------------------------------
	assign tapCount  = 8'h01 << lnk.tapsLog2;
	assign oldIdx    = wrPtr_reg - tapCount[6:0];  // N of 128 wraps onto the slot being replaced
	assign oldSample = hist_reg[oldIdx];
	assign sum_next  = sum_reg + {{7{lnk.inData[31]}}, lnk.inData}
		- {{7{oldSample[31]}}, oldSample};
	assign avgShift  = sum_next >>> lnk.tapsLog2;

	// History entries, cleared together on a size change
	for (genvar i = 0; i < iabf_pkg::HIST_DEPTH; i++) begin : g_hist
		always_ff @(posedge clk) begin
			if (srst || lnk.flush)
				hist_reg[i] <= 32'h0000_0000;
			else if (lnk.inValid && wrPtr_reg == 7'(i))
				hist_reg[i] <= lnk.inData;
		end
	end

	// Pointer, sum and output word
	always_ff @(posedge clk) begin
		if (srst || lnk.flush) begin
			wrPtr_reg    <= 7'h00;
			sum_reg      <= '0;
			outData_reg  <= 32'h0000_0000;
			outValid_reg <= 1'b0;
		end else begin
			outValid_reg <= lnk.inValid;
			if (lnk.inValid) begin
				wrPtr_reg   <= wrPtr_reg + 7'h01;
				sum_reg     <= sum_next;
				outData_reg <= avgShift[31:0];
			end
		end
	end

	assign lnk.outData  = outData_reg;
	assign lnk.outValid = outValid_reg;

endmodule // iabf_boxcar

/* File: logic/iabf_regs.sv */
// Purpose: Accelerometer bias words, averaging filter size, range identifier, misc control
// Assumes: Host commands arrive already deframed: one byte per write, one word per read
// Notes:   Bias is added ahead of the two cascaded averaging stages
//
// Overview of operation
// R01 - X low register holds the lower sixteen bits of the 32-bit offset.
// R02 - X high register holds the upper sixteen bits of that offset.
// R03 - High and low words join into one offset; high alone is data format.
// R04 - Each axis offset is added to its accelerometer sample, same for x, y, z.
// R05 - Filter field B sets N equals two to the power B taps per stage.
// R06 - Output filter is two cascaded averaging stages sharing the same N.
// R07 - Host programs 16 taps by writing 0x04 low byte, then 0x00 high byte.
// R08 - Range register bits 3:2 report gyro range code; 10 is reserved.
// R09 - Range register bits 1:0 always read binary 11.
// R10 - Misc bit 9 selects 32-bit burst words when set, 16-bit by default.
// R11 - New burst width takes effect only after one full data ready period.
// R12 - Misc bits 9, 8, 7 may take up to 200 us to read back.
// R13 - Misc bit 8 selects delta burst content; default is calibrated data.
// R14 - Burst width and select bits exist only from firmware 1.34 onward.
// R15 - Misc bit 7 enables linear-g compensation of gyroscope outputs.
// R16 - Misc bit 6 enables point-of-percussion alignment, on by default.
// R17 - Misc bits 4:2 select sync function; 000 internal clock default.
// R18 - Bit 1 picks sync edge, falling default; bit 0 ready polarity, high default.
// R19 - Each register spans two byte addresses, low byte even; writes hit one byte.
// R20 - Unused bits read zero and ignore writes.
`timescale 1ns/1ns
module iabf_regs #(
	parameter logic [1:0] GYRO_RANGE   = 2'h3,  // Range model code of this build
	parameter logic       HAS_BURST_CTL = 1'b1  // Firmware 1.34 or newer
) (
	input  wire logic              clk,
	input  wire logic              srst,
	input  wire logic              regReq,
	input  wire logic              regWrite,
	input  wire logic [6:0]        regAddr,
	input  wire logic [7:0]        regWrData,
	output logic      [15:0]       regRdData,
	output logic                   regRdValid,
	input  wire logic              sampleStrobe,
	input  wire logic [2:0][31:0]  accelRaw,
	output logic      [2:0][31:0]  accelFiltered,
	output logic                   accelFilteredValid,
	output logic                   sampleValidFlag,
	output logic                   burstWideWords,
	output logic                   burstDeltaSel,
	output logic                   linearGComp,
	output logic                   percussionAlign,
	output logic      [2:0]        syncMode,
	output logic                   syncRisingEdge
);

	logic [15:0]                     offset_reg [6];
	logic [2:0]                      filter_reg;
	logic [15:0]                     misc_reg;
	logic [15:0]                     rdData_reg;
	logic                            rdValid_reg;
	logic [2:0][31:0]                biased_reg;
	logic                            biasedValid_reg;
	logic                            burstWide_reg;
	iabf_pkg::iabf_burst_state_type  burstState_reg;
	iabf_pkg::iabf_burst_state_type  burstState_next;

	// ---------------------------------------------------------------
	// Address decode
	// ---------------------------------------------------------------
	wire        wrStrobe   = regReq && regWrite;
	wire        rdStrobe   = regReq && !regWrite;
	wire [6:0]  wordAddr   = {regAddr[6:1], 1'b0};
	wire [6:0]  offRel     = wordAddr - iabf_pkg::ADDR_ACCEL_X_LO;
	wire [2:0]  offIdx     = offRel[3:1];
	wire        offHit     = regAddr >= iabf_pkg::ADDR_ACCEL_X_LO
		&& regAddr <= iabf_pkg::ADDR_OFFSET_END;
	wire        filterHit  = wordAddr == iabf_pkg::ADDR_FILTER;
	wire        rangeHit   = wordAddr == iabf_pkg::ADDR_RANGE;
	wire        miscHit    = wordAddr == iabf_pkg::ADDR_MISC;
	wire        highByte   = regAddr[0];                               // [R19]
	wire [15:0] miscMask   = HAS_BURST_CTL ? iabf_pkg::MISC_WR_MASK
		: iabf_pkg::MISC_WR_MASK_OLD;                                  // [R14] [R20]
	wire [15:0] rangeWord  = {12'h000, GYRO_RANGE, iabf_pkg::RANGE_RESERVED}; // [R08] [R09]
	wire        filterWrLo = wrStrobe && filterHit && !highByte;
	wire        filterChg  = filterWrLo && regWrData[2:0] != filter_reg;

	// Offset words: one byte lane per write
	for (genvar r = 0; r < 6; r++) begin : g_offset
		always_ff @(posedge clk) begin
			if (srst)
				offset_reg[r] <= iabf_pkg::OFFSET_RESET;
			else if (wrStrobe && offHit && offIdx == 3'(r) && !highByte)
				offset_reg[r][7:0] <= regWrData;                       // [R01] [R19]
			else if (wrStrobe && offHit && offIdx == 3'(r) && highByte)
				offset_reg[r][15:8] <= regWrData;                      // [R02] [R19]
		end
	end

	// Filter size: only B is kept, the high byte has nothing to store
	always_ff @(posedge clk) begin
		if (srst)
			filter_reg <= iabf_pkg::FILTER_RESET;
		else if (filterWrLo)
			filter_reg <= regWrData[2:0];                              // [R05] [R07] [R20]
	end

	// Misc control applies at once, well inside the readback allowance
	always_ff @(posedge clk) begin
		if (srst)
			misc_reg <= iabf_pkg::MISC_RESET & miscMask;
		else if (wrStrobe && miscHit && !highByte)
			misc_reg[7:0] <= regWrData & miscMask[7:0];                // [R12] [R15] [R16] [R18]
		else if (wrStrobe && miscHit && highByte)
			misc_reg[15:8] <= regWrData & miscMask[15:8];              // [R10] [R13] [R14]
	end

	// ---------------------------------------------------------------
	// Read path: one word, answered on the following cycle
	// ---------------------------------------------------------------
	wire [15:0] rdMux = offHit ? offset_reg[offIdx]
		: filterHit ? {13'h0000, filter_reg}
		: rangeHit ? rangeWord
		: miscHit ? misc_reg
		: 16'h0000;                                                    // [R20]

	always_ff @(posedge clk) begin
		if (srst) begin
			rdData_reg  <= 16'h0000;
			rdValid_reg <= 1'b0;
		end else begin
			rdValid_reg <= rdStrobe;
			if (rdStrobe)
				rdData_reg <= rdMux;
		end
	end

	assign regRdData  = rdData_reg;
	assign regRdValid = rdValid_reg;

	// ---------------------------------------------------------------
	// Bias stage: offset = {high, low}, added per axis
	// ---------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (srst) begin
			biased_reg      <= '0;
			biasedValid_reg <= 1'b0;
		end else begin
			biasedValid_reg <= sampleStrobe;
			for (int a = 0; a < iabf_pkg::AXES; a++) begin
				if (sampleStrobe)
					biased_reg[a] <= accelRaw[a]
						+ {offset_reg[2*a+1], offset_reg[2*a]};        // [R03] [R04]
			end
		end
	end

	// ---------------------------------------------------------------
	// Two cascaded averaging stages per axis, same tap count
	// ---------------------------------------------------------------
	logic [2:0] stageValid;
	for (genvar a = 0; a < iabf_pkg::AXES; a++) begin : g_axis
		iabf_avg_if first ();
		iabf_avg_if second ();
		assign first.inData    = biased_reg[a];
		assign first.inValid   = biasedValid_reg;
		assign first.tapsLog2  = filter_reg;                           // [R05]
		assign first.flush     = filterChg;
		assign second.inData   = first.outData;                        // [R06]
		assign second.inValid  = first.outValid;
		assign second.tapsLog2 = filter_reg;                           // [R06]
		assign second.flush    = filterChg;
		assign accelFiltered[a] = second.outData;
		assign stageValid[a]    = second.outValid;
		iabf_boxcar u_first (
			.clk  (clk),
			.srst (srst),
			.lnk  (first)
		);
		iabf_boxcar u_second (
			.clk  (clk),
			.srst (srst),
			.lnk  (second)
		);
	end

	assign accelFilteredValid = stageValid[0];
	// Data ready pin level follows the chosen polarity
	assign sampleValidFlag = misc_reg[iabf_pkg::MISC_READY_POL]
		? stageValid[0] : !stageValid[0];                              // [R18]

	// ---------------------------------------------------------------
	// Burst width refresh: wait one whole sample period
	// ---------------------------------------------------------------
	// The burst array is rebuilt per sample, so a mid-period switch would mix formats
	wire burstCfg = misc_reg[iabf_pkg::MISC_BURST_WIDE];

	always_comb begin
		burstState_next = burstState_reg;
		case (burstState_reg)
			iabf_pkg::BURST_IDLE:
				if (burstCfg != burstWide_reg)
					burstState_next = iabf_pkg::BURST_ARM;
			iabf_pkg::BURST_ARM:
				if (sampleStrobe)
					burstState_next = iabf_pkg::BURST_PERIOD;
			iabf_pkg::BURST_PERIOD:
				if (sampleStrobe)
					burstState_next = iabf_pkg::BURST_IDLE;
			default:
				burstState_next = iabf_pkg::BURST_IDLE;
		endcase
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			burstState_reg <= iabf_pkg::BURST_IDLE;
			burstWide_reg  <= 1'b0;
		end else begin
			burstState_reg <= burstState_next;
			if (burstState_reg == iabf_pkg::BURST_PERIOD && sampleStrobe)
				burstWide_reg <= burstCfg;                             // [R11]
		end
	end

	assign burstWideWords  = burstWide_reg;                            // [R10]
	assign burstDeltaSel   = misc_reg[iabf_pkg::MISC_BURST_SEL];       // [R13]
	assign linearGComp     = misc_reg[iabf_pkg::MISC_LINEAR_G];        // [R15]
	assign percussionAlign = misc_reg[iabf_pkg::MISC_POP];             // [R16]
	assign syncMode        = misc_reg[iabf_pkg::MISC_SYNC_LSB +: 3];   // [R17]
	assign syncRisingEdge  = misc_reg[iabf_pkg::MISC_SYNC_EDGE];       // [R18]

	// ---------------------------------------------------------------
	// Assertions
	// ---------------------------------------------------------------
	property p_bias_sum;
		@(posedge clk) disable iff (srst)
		sampleStrobe |=> biased_reg[0] == $past(accelRaw[0])
			+ $past({offset_reg[1], offset_reg[0]});
	endproperty
	a_bias_sum: assert property (p_bias_sum) else $error("x bias sum wrong"); // [R04]

	property p_low_byte;
		@(posedge clk) disable iff (srst)
		(wrStrobe && regAddr == iabf_pkg::ADDR_ACCEL_X_LO)
			|=> offset_reg[0] == {$past(offset_reg[0][15:8]), $past(regWrData)};
	endproperty
	a_low_byte: assert property (p_low_byte) else $error("x low byte write wrong"); // [R01]

	property p_high_byte;
		@(posedge clk) disable iff (srst)
		(wrStrobe && regAddr == iabf_pkg::ADDR_ACCEL_X_HI + 7'h01)
			|=> offset_reg[1] == {$past(regWrData), $past(offset_reg[1][7:0])};
	endproperty
	a_high_byte: assert property (p_high_byte) else $error("x high byte write wrong"); // [R02]

	property p_range_read;
		@(posedge clk) disable iff (srst)
		(rdStrobe && regAddr == iabf_pkg::ADDR_RANGE)
			|=> regRdValid && regRdData[3:2] == GYRO_RANGE;
	endproperty
	a_range_read: assert property (p_range_read) else $error("range code wrong"); // [R08]

	property p_range_reserved;
		@(posedge clk) disable iff (srst)
		(rdStrobe && regAddr == iabf_pkg::ADDR_RANGE) |=> regRdData[1:0] == 2'h3;
	endproperty
	a_range_reserved: assert property (p_range_reserved) else $error("reserved not 11"); // [R09]

	property p_filter_unused;
		@(posedge clk) disable iff (srst)
		(rdStrobe && filterHit) |=> regRdData[15:3] == 13'h0000;
	endproperty
	a_filter_unused: assert property (p_filter_unused) else $error("filter unused not 0"); // [R20]

	property p_burst_hold;
		@(posedge clk) disable iff (srst)
		$changed(burstWideWords) |-> $past(sampleStrobe)
			&& $past(burstState_reg) == iabf_pkg::BURST_PERIOD;
	endproperty
	a_burst_hold: assert property (p_burst_hold) else $error("burst width early"); // [R11]

	property p_old_rev;
		@(posedge clk) disable iff (srst)
		!HAS_BURST_CTL |-> misc_reg[9:8] == 2'h0;
	endproperty
	a_old_rev: assert property (p_old_rev) else $error("burst bits on old rev"); // [R14]

	property p_cascade;
		@(posedge clk) disable iff (srst || filterChg)
		sampleStrobe |-> ##3 accelFilteredValid;
	endproperty
	a_cascade: assert property (p_cascade) else $error("cascade latency wrong"); // [R06]

	property p_misc_reset;
		@(posedge clk) $fell(srst) |-> misc_reg == (iabf_pkg::MISC_RESET & miscMask)
			&& !burstWideWords;
	endproperty
	a_misc_reset: assert property (p_misc_reset) else $error("misc reset wrong"); // [R10]

	c_burst_switch: cover property (@(posedge clk) disable iff (srst) $rose(burstWideWords));
	c_filter16: cover property (@(posedge clk) disable iff (srst)
		filterWrLo && regWrData[2:0] == 3'h4);
	c_misc_write: cover property (@(posedge clk) disable iff (srst) wrStrobe && miscHit);

endmodule // iabf_regs

/* File: shared/iabf_avg_if.sv */
// Purpose: Carrier between the register bank and one averaging stage
// Assumes: One sample per inValid pulse
// Notes:   flush empties the stage history
`timescale 1ns/1ns
interface iabf_avg_if;
	logic [31:0] inData;
	logic        inValid;
	logic [2:0]  tapsLog2;
	logic        flush;
	logic [31:0] outData;
	logic        outValid;

	modport stage (input inData, input inValid, input tapsLog2, input flush,
		output outData, output outValid);
	modport feed (output inData, output inValid, output tapsLog2, output flush,
		input outData, input outValid);
endinterface

/* File: shared/iabf_pkg.sv */
// Purpose: Constants and types for the accelerometer bias, filter and misc register bank
// Assumes: Byte-wide register writes, 16-bit register reads, 50 MHz clock
// Notes:   Every offset, register reset value and misc field position lives here
package iabf_pkg;

	// ---------------------------------------------------------------
	// Data path sizes
	// ---------------------------------------------------------------
	localparam int DATA_W     = 32;
	localparam int SUM_W      = 39;
	localparam int HIST_DEPTH = 128;
	localparam int AXES       = 3;

	// ---------------------------------------------------------------
	// Register byte addresses (low byte at the even address)
	// ---------------------------------------------------------------
	localparam logic [6:0] ADDR_ACCEL_X_LO = 7'h4c;
	localparam logic [6:0] ADDR_ACCEL_X_HI = 7'h4e;
	localparam logic [6:0] ADDR_ACCEL_Y_LO = 7'h50;
	localparam logic [6:0] ADDR_ACCEL_Y_HI = 7'h52;
	localparam logic [6:0] ADDR_ACCEL_Z_LO = 7'h54;
	localparam logic [6:0] ADDR_ACCEL_Z_HI = 7'h56;
	localparam logic [6:0] ADDR_OFFSET_END = 7'h57;
	localparam logic [6:0] ADDR_FILTER     = 7'h5c;
	localparam logic [6:0] ADDR_RANGE      = 7'h5e;
	localparam logic [6:0] ADDR_MISC       = 7'h60;

	// ---------------------------------------------------------------
	// Reset values and write masks
	// ---------------------------------------------------------------
	localparam logic [15:0] OFFSET_RESET      = 16'h0000;
	localparam logic [2:0]  FILTER_RESET      = 3'h0;
	localparam logic [15:0] MISC_RESET        = 16'h00c1;
	localparam logic [15:0] MISC_WR_MASK      = 16'h03df;
	localparam logic [15:0] MISC_WR_MASK_OLD  = 16'h00df;
	localparam logic [1:0]  RANGE_RESERVED    = 2'h3;

	// ---------------------------------------------------------------
	// Field positions of the misc control register
	// ---------------------------------------------------------------
	localparam int MISC_BURST_WIDE = 9;
	localparam int MISC_BURST_SEL  = 8;
	localparam int MISC_LINEAR_G   = 7;
	localparam int MISC_POP        = 6;
	localparam int MISC_SYNC_LSB   = 2;
	localparam int MISC_SYNC_EDGE  = 1;
	localparam int MISC_READY_POL  = 0;

	// Burst width refresh sequencing
	typedef enum logic [1:0] {
		BURST_IDLE   = 2'b00,
		BURST_ARM    = 2'b01,
		BURST_PERIOD = 2'b10
	} iabf_burst_state_type;

endpackage
